/* hw/io_base_decode.sv */
/*
  Maps the three-bit base code to a host I/O base and decodes the 20H window.
  Assumes the address is a registered or stable 16-bit host I/O address.
*/
`timescale 1ns/10ps
module io_base_decode
  import mode_cfg_pkg::*;
(
  // Configuration
  input wire logic [2:0] io_base_select,
  // Host address
  input wire logic [15:0] addr,
  // Decode result
  output logic hit,
  output logic [3:0] offset
);
  logic [15:0] base;
  logic valid;

  always_comb begin
    valid = 1'b1;
    case (io_base_select)
      3'h0: base = 16'h0300;
      3'h2: base = 16'h0240;
      3'h3: base = 16'h0280;
      3'h4: base = 16'h02c0;
      3'h5: base = 16'h0320;
      3'h6: base = 16'h0340;
      default: begin
        // Software-placed code and the unlisted code answer nothing.
        base = 16'h0000;
        valid = 1'b0;
      end
    endcase
  end

  assign hit = valid && ((addr & IO_WINDOW_MASK) == base); // RULE5 RULE6
  assign offset = addr[3:0];
endmodule

/* hw/mode_config_regs.sv */
/*
  Hidden mode configuration registers on page 0 of the host I/O window, with the
  pin-level outputs that their fields steer.
  Assumes host I/O strobes arrive as one-cycle pulses synchronous to ref_clk, and
  that the surrounding controller supplies page select, link status and events.
*/
//
// Overview of operation
// RULE1: Read 0AH shows first register; write lands only right after that read.
// RULE2: Otherwise a write at 0AH goes to remote byte count low.
// RULE3: Read 0BH shows second register; write lands only right after that read.
// RULE4: Otherwise a write at 0BH goes to remote byte count high.
// RULE5: Base code picks I/O base 0300H, 0240H, 0280H, 02C0H, 0320H or 0340H.
// RULE6: Device decodes 20H consecutive addresses from the selected base.
// RULE7: Code 001 answers nothing; four writes to 278H load base, once only.
// RULE8: Direct mode drives one chosen interrupt pin; other three float.
// RULE9: Coded mode uses fourth pin as request, others mirror bits 3 to 5.
// RULE10: Early-fetch bit in I/O mode starts next port fetch before read ends.
// RULE11: First register bit 7 picks shared-memory (1) or I/O-port (0) mode.
// RULE12: Media field picks standard TP, thin AUI, thick AUI or reduced-squelch TP.
// RULE13: Coax-power output low for thick coax, high for thin coax.
// RULE14: Writing 1 to link-test bit disables link pulses and integrity check.
// RULE15: Link-test read is 0 for AUI or bad link, else 1; code reads 1 on bad link while link test is disabled.
// RULE16: Bit 3 set delays wide-I/O acknowledge until a strobe; clear uses decode.
// RULE17: Bit 4 clear gives ready after command strobe; set after address latch.
// RULE18: Bus-fault flag sets when requested wait states are not honoured.
// RULE19: Writing one clears the bus-fault flag; zero leaves it.
// RULE20: Boot-PROM write enable low blocks all boot-PROM write cycles.
// RULE21: Writing 1 to bit 7 of second register starts serial ROM reload.
// RULE22: Host must not read-modify-write the second register.
// RULE23: Strap bit 5 low selects direct interrupts, high selects coded.
// RULE24: Strap bit 7 high hides both registers from software.
// RULE25: Any other I/O access resets the count of soft-config writes.
`timescale 1ns/10ps
module mode_config_regs
  import mode_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Reset-loaded hardware configuration
  input wire logic [7:0] hw_config_strap,
  // Host I/O cycle, one-cycle strobes
  input wire host_io_t host,
  input wire logic page0_sel,
  output logic io_hit,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output rbc_write_t rbc_write,
  // Bus timing events and controls
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic ale,
  input wire logic wait_wanted,
  input wire logic cycle_end,
  output logic wide_io_ack,
  output logic ready_arm,
  // Data port and boot memory
  input wire logic port_read_active,
  input wire logic boot_wr_req,
  output logic early_port_fetch,
  output logic boot_wr_cycle,
  output logic shared_memory_select,
  // Interrupt pins
  input wire logic irq_req,
  output logic [2:0] irq_route_out,
  output logic [2:0] irq_route_oe,
  output logic irq_line_fourth,
  output logic irq_line_fourth_oe,
  // Media
  input wire logic link_good,
  output logic [1:0] media_select,
  output logic coax_power,
  output logic link_test_disable,
  output logic reduced_squelch,
  output logic twisted_pair_port,
  output logic serial_rom_reload
);
  logic [7:0] bus_mode_config;
  logic [7:0] media_bus_option_config;
  logic bus_fault_flag;
  logic [7:0] strap;
  logic strap_taken;
  arm_state_t arm;
  logic [2:0] soft_count;
  logic soft_used;
  logic [3:0] ofs;
  logic any_access;
  logic cfg_open;
  logic wr_bus_mode;
  logic wr_media_opt;
  logic soft_wr;
  logic link_test_ctl;
  logic [2:0] irq_route_field;
  logic wait_pending;

  io_base_decode u_decode (
    .io_base_select(bus_mode_config[IO_BASE_LSB +: 3]),
    .addr(host.addr),
    .hit(io_hit),
    .offset(ofs)
  );

  // ****************************************
  // Strap capture after reset release
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap <= 8'h00;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap <= hw_config_strap;
      strap_taken <= 1'b1;
    end
  end

  // ****************************************
  // Hidden write arming
  // ****************************************
  assign any_access = (host.rd || host.wr) && io_hit;
  assign cfg_open = strap_taken && !strap[STRAP_LOCK_BIT]; // RULE24
  assign wr_bus_mode = host.wr && io_hit && page0_sel && ofs == OFS_BUS_MODE
                       && arm == ARM_BUS_MODE && cfg_open; // RULE1
  assign wr_media_opt = host.wr && io_hit && page0_sel && ofs == OFS_MEDIA_OPT
                        && arm == ARM_MEDIA_OPT && cfg_open; // RULE3

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arm <= ARM_NONE;
    end else if (any_access) begin
      // Any access in the I/O window, including the hidden write itself, disarms; only a read re-arms.
      if (host.rd && page0_sel && ofs == OFS_BUS_MODE) begin
        arm <= ARM_BUS_MODE;
      end else if (host.rd && page0_sel && ofs == OFS_MEDIA_OPT) begin
        arm <= ARM_MEDIA_OPT;
      end else begin
        arm <= ARM_NONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rbc_write <= '0;
    end else begin
      rbc_write.rbc_lo_wr <= host.wr && io_hit && page0_sel && ofs == OFS_BUS_MODE
                             && !wr_bus_mode; // RULE2
      rbc_write.rbc_hi_wr <= host.wr && io_hit && page0_sel && ofs == OFS_MEDIA_OPT
                             && !wr_media_opt; // RULE4
      rbc_write.wdata <= host.wdata;
    end
  end

  // ****************************************
  // Software placement of the I/O base
  // ****************************************
  assign soft_wr = host.wr && host.addr == SOFT_CFG_ADDR && !soft_used
                   && bus_mode_config[IO_BASE_LSB +: 3] == IO_BASE_SOFT;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_count <= 3'h0;
    end else if (soft_wr) begin
      soft_count <= (soft_count == SOFT_WRITES - 3'h1) ? 3'h0 : soft_count + 3'h1; // RULE7
    end else if (host.rd || host.wr) begin
      soft_count <= 3'h0; // RULE25
    end
  end

  // Only a reset on rst rearms the one-shot sequence.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_used <= 1'b0;
    end else if (soft_wr && soft_count == SOFT_WRITES - 3'h1) begin
      soft_used <= 1'b1; // RULE7
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_mode_config <= BUS_MODE_RESET;
    end else if (wr_bus_mode) begin
      bus_mode_config <= host.wdata; // RULE1
    end else if (soft_wr && soft_count == SOFT_WRITES - 3'h1) begin
      bus_mode_config[IO_BASE_LSB +: 3] <= host.wdata[IO_BASE_LSB +: 3]; // RULE7
    end
  end

  // The fault flag and reload trigger are held apart from the stored byte.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      media_bus_option_config <= MEDIA_OPT_RESET;
    end else if (wr_media_opt) begin
      media_bus_option_config <= host.wdata; // RULE3
      media_bus_option_config[BUS_FAULT_BIT] <= 1'b0;
      media_bus_option_config[RELOAD_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_rom_reload <= 1'b0;
    end else begin
      serial_rom_reload <= wr_media_opt && host.wdata[RELOAD_BIT]; // RULE21
    end
  end

  // ****************************************
  // Bus fault detection
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_pending <= 1'b0;
    end else if (cycle_end) begin
      wait_pending <= 1'b0;
    end else if (wait_wanted) begin
      wait_pending <= 1'b1;
    end
  end

  // A new fault wins over a clear written in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_fault_flag <= 1'b0;
    end else if (cycle_end && (wait_pending || wait_wanted)) begin
      bus_fault_flag <= 1'b1; // RULE18
    end else if (wr_media_opt && host.wdata[BUS_FAULT_BIT]) begin
      bus_fault_flag <= 1'b0; // RULE19
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  assign link_test_ctl = !twisted_pair_port ? 1'b0 :
                         (link_test_disable || link_good); // RULE15

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= host.rd && io_hit && page0_sel && cfg_open
                  && (ofs == OFS_BUS_MODE || ofs == OFS_MEDIA_OPT);
      if (ofs == OFS_BUS_MODE) begin
        rd_data <= bus_mode_config; // RULE1
      end else begin
        rd_data <= {1'b0, media_bus_option_config[BOOT_WR_BIT], bus_fault_flag,
                    media_bus_option_config[READY_ALE_BIT:WIDE_ACK_BIT],
                    link_test_ctl, media_bus_option_config[MEDIA_LSB +: 2]}; // RULE3
      end
    end
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  assign media_select = media_bus_option_config[MEDIA_LSB +: 2]; // RULE12
  assign twisted_pair_port = media_select == MEDIA_TP_STD || media_select == MEDIA_TP_LOW;
  assign reduced_squelch = media_select == MEDIA_TP_LOW;
  assign link_test_disable = media_bus_option_config[LINK_TEST_BIT]; // RULE14
  assign shared_memory_select = bus_mode_config[SHARED_MEM_BIT]; // RULE11

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coax_power <= 1'b0;
    end else if (media_select == MEDIA_THICK) begin
      coax_power <= 1'b0; // RULE13
    end else if (media_select == MEDIA_THIN) begin
      coax_power <= 1'b1; // RULE13
    end
  end

  // ****************************************
  // Bus timing controls
  // ****************************************
  assign wide_io_ack = io_hit && (!media_bus_option_config[WIDE_ACK_BIT]
                       || !ior_n || !iow_n); // RULE16
  assign ready_arm = io_hit && (media_bus_option_config[READY_ALE_BIT] ? ale
                     : (!ior_n || !iow_n)); // RULE17
  assign early_port_fetch = bus_mode_config[EARLY_FETCH_BIT] && !shared_memory_select
                            && port_read_active; // RULE10
  assign boot_wr_cycle = boot_wr_req && media_bus_option_config[BOOT_WR_BIT]; // RULE20

  // ****************************************
  // Interrupt pins
  // ****************************************
  assign irq_route_field = bus_mode_config[IRQ_ROUTE_LSB +: 3];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_route_out <= 3'h0;
      irq_route_oe <= 3'h0;
      irq_line_fourth <= 1'b0;
      irq_line_fourth_oe <= 1'b0;
    end else if (strap[STRAP_IRQ_STYLE_BIT]) begin // RULE23
      irq_route_out <= irq_route_field; // RULE9
      irq_route_oe <= 3'h7;
      irq_line_fourth <= irq_req;
      irq_line_fourth_oe <= 1'b1;
    end else begin
      irq_route_out <= {3{irq_req}};
      irq_line_fourth <= irq_req;
      // The upper select bit is ignored; codes x11 map to the fourth pin.
      case (irq_route_field[1:0])
        2'h0: irq_route_oe <= 3'h1; // RULE8
        2'h1: irq_route_oe <= 3'h2;
        2'h2: irq_route_oe <= 3'h4;
        default: irq_route_oe <= 3'h0;
      endcase
      irq_line_fourth_oe <= irq_route_field[1:0] == 2'h3;
    end
  end
endmodule

/* include/mode_cfg_pkg.sv */
/*
  Shared constants and carrier types for the hidden mode configuration registers.
  Assumes a synchronous host I/O cycle interface already qualified to one-cycle strobes.
*/
package mode_cfg_pkg;
  // ****************************************
  // Register offsets within page 0
  // ****************************************
  localparam logic [3:0] OFS_BUS_MODE = 4'ha;
  localparam logic [3:0] OFS_MEDIA_OPT = 4'hb;
  // ****************************************
  // Field positions, first register
  // ****************************************
  localparam int IO_BASE_LSB = 0;
  localparam int IRQ_ROUTE_LSB = 3;
  localparam int EARLY_FETCH_BIT = 6;
  localparam int SHARED_MEM_BIT = 7;
  // ****************************************
  // Field positions, second register
  // ****************************************
  localparam int MEDIA_LSB = 0;
  localparam int LINK_TEST_BIT = 2;
  localparam int WIDE_ACK_BIT = 3;
  localparam int READY_ALE_BIT = 4;
  localparam int BUS_FAULT_BIT = 5;
  localparam int BOOT_WR_BIT = 6;
  localparam int RELOAD_BIT = 7;
  // ****************************************
  // Strap positions of the reset-loaded hardware register
  // ****************************************
  localparam int STRAP_IRQ_STYLE_BIT = 5;
  localparam int STRAP_LOCK_BIT = 7;
  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] BUS_MODE_RESET = 8'h00;
  localparam logic [7:0] MEDIA_OPT_RESET = 8'h00;
  localparam logic [2:0] IO_BASE_SOFT = 3'h1;
  localparam logic [15:0] SOFT_CFG_ADDR = 16'h0278;
  localparam logic [2:0] SOFT_WRITES = 3'h4;
  localparam logic [15:0] IO_WINDOW = 16'h0020;
  localparam logic [15:0] IO_WINDOW_MASK = 16'hffe0;
  localparam logic [1:0] MEDIA_TP_STD = 2'h0;
  localparam logic [1:0] MEDIA_THIN = 2'h1;
  localparam logic [1:0] MEDIA_THICK = 2'h2;
  localparam logic [1:0] MEDIA_TP_LOW = 2'h3;

  typedef enum logic [1:0] {
    ARM_NONE = 2'b00,
    ARM_BUS_MODE = 2'b01,
    ARM_MEDIA_OPT = 2'b11
  } arm_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } host_io_t;

  typedef struct packed {
    logic rbc_lo_wr;
    logic rbc_hi_wr;
    logic [7:0] wdata;
  } rbc_write_t;
endpackage

/* verification/host_io_master.sv */
/*
  Host bus master model that issues single I/O cycles toward the device.
  Assumes one-cycle strobes taken on the rising edge of ref_clk.
*/
`timescale 1ns/10ps
module host_io_master
  import mode_cfg_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Host cycle
  output host_io_t host,
  output logic ior_n,
  output logic iow_n,
  output logic ale
);
  initial begin
    host = '0;
    ior_n = 1'b1;
    iow_n = 1'b1;
    ale = 1'b0;
  end
  // One whole access per call; released address and data lines are inverted so a stale value
  // never passes for a driven one.
  task automatic io_cycle(input logic is_wr, input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    host.rd <= !is_wr;
    host.wr <= is_wr;
    host.addr <= a;
    host.wdata <= v;
    ior_n <= is_wr;
    iow_n <= !is_wr;
    ale <= 1'b1;
    @(posedge ref_clk);
    host.rd <= 1'b0;
    host.wr <= 1'b0;
    host.addr <= ~a;
    host.wdata <= ~v;
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    ale <= 1'b0;
  endtask
  task automatic probe(input logic [15:0] a);
    @(posedge ref_clk);
    host.addr <= a;
  endtask
  // Holds an address with a chosen read strobe and latch level, no access.
  task automatic hold(input logic [15:0] a, input logic rd_n, input logic al);
    @(posedge ref_clk);
    host.addr <= a;
    ior_n <= rd_n;
    ale <= al;
  endtask
endmodule

/* verification/mode_config_regs_assertions.sv */
/*
  Checker for the hidden mode configuration registers, bound to mode_config_regs.
  Assumes the strap input changes only while reset is held.
*/
`timescale 1ns/10ps
module mode_config_regs_assertions
  import mode_cfg_pkg::*;
(
  // Clock, reset and strap
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] hw_config_strap,
  // Host side
  input wire host_io_t host,
  input wire logic page0_sel,
  input wire logic io_hit,
  input wire logic rd_valid,
  input wire rbc_write_t rbc_write,
  // Pin outputs
  input wire logic early_port_fetch,
  input wire logic shared_memory_select,
  input wire logic [2:0] irq_route_oe,
  input wire logic irq_line_fourth_oe,
  input wire logic [1:0] media_select,
  input wire logic coax_power,
  input wire logic twisted_pair_port,
  input wire logic serial_rom_reload
);
  // ****************************************
  // Helper logic and properties
  // ****************************************
  logic [1:0] up_cnt;
  logic cfg_rd;
  assign cfg_rd = host.rd && io_hit && page0_sel && host.addr[4:1] == 4'h5;
  // The strap is taken after release, so settled checks wait three edges.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  AST_RD_VALID: assert property (cfg_rd && !hw_config_strap[7] && up_cnt == 2'h3 |=> rd_valid)
    else $error("hidden register read gave no data strobe");
  AST_RBC_LO: assert property (rbc_write.rbc_lo_wr |-> $past(host.wr && io_hit && host.addr[4:0] == 5'h0a))
    else $error("low byte count write without a write at 0AH");
  AST_RBC_HI: assert property (rbc_write.rbc_hi_wr |-> $past(host.wr && io_hit && host.addr[4:0] == 5'h0b))
    else $error("high byte count write without a write at 0BH");
  AST_COAX_THICK: assert property ((media_select == MEDIA_THICK) [*2] |-> !coax_power)
    else $error("coax power high with thick media");
  AST_COAX_THIN: assert property ((media_select == MEDIA_THIN) [*2] |-> coax_power)
    else $error("coax power low with thin media");
  AST_TP_PORT: assert property (twisted_pair_port == (media_select[1] == media_select[0]))
    else $error("twisted pair select disagrees with media");
  AST_FETCH_IO: assert property (early_port_fetch |-> !shared_memory_select)
    else $error("early fetch in shared memory mode");
  AST_RELOAD: assert property (serial_rom_reload |-> $past(host.wr && host.wdata[7] && io_hit))
    else $error("reload pulse without a write of bit 7");
  AST_IRQ_DIRECT: assert property (!hw_config_strap[5] |-> $onehot0({irq_route_oe, irq_line_fourth_oe}))
    else $error("more than one interrupt pin driven");
  AST_IRQ_CODED: assert property (hw_config_strap[5] && up_cnt == 2'h3 |-> irq_line_fourth_oe && irq_route_oe == 3'h7)
    else $error("coded interrupt pins not all driven");
  COV_RBC: cover property (rbc_write.rbc_lo_wr);
  COV_RELOAD: cover property (serial_rom_reload);
  COV_READ: cover property (cfg_rd ##1 rd_valid);
endmodule

bind mode_config_regs mode_config_regs_assertions i_chk (
  .ref_clk, .rst, .hw_config_strap, .host, .page0_sel, .io_hit, .rd_valid, .rbc_write,
  .early_port_fetch, .shared_memory_select, .irq_route_oe, .irq_line_fourth_oe,
  .media_select, .coax_power, .twisted_pair_port, .serial_rom_reload
);

/* verification/mode_config_regs_tb_top.sv */
/*
  Self-checking testbench for mode_config_regs driven by the host master model.
  Assumes the design package and host_io_master are compiled first.
*/
`timescale 1ns/10ps
module mode_config_regs_tb_top import mode_cfg_pkg::*;;
  logic ref_clk, rst, page0_sel, io_hit, rd_valid, ior_n, iow_n, ale, wait_wanted;
  logic cycle_end, wide_io_ack, ready_arm, port_read_active, boot_wr_req, early_port_fetch;
  logic boot_wr_cycle, shared_memory_select, irq_req, irq_line_fourth, irq_line_fourth_oe;
  logic link_good, coax_power, link_test_disable, reduced_squelch, twisted_pair_port;
  logic serial_rom_reload;
  logic [7:0] hw_config_strap, rd_data, d;
  logic [2:0] irq_route_out, irq_route_oe;
  logic [1:0] media_select;
  logic [15:0] base;
  host_io_t host;
  rbc_write_t rbc_write;
  int fails, samples_checked;

  host_io_master i_host (.ref_clk, .host, .ior_n, .iow_n, .ale);
  mode_config_regs i_dut (.ref_clk, .rst, .hw_config_strap, .host, .page0_sel, .io_hit,
    .rd_valid, .rd_data, .rbc_write, .ior_n, .iow_n, .ale, .wait_wanted, .cycle_end,
    .wide_io_ack, .ready_arm, .port_read_active, .boot_wr_req, .early_port_fetch,
    .boot_wr_cycle, .shared_memory_select, .irq_req, .irq_route_out, .irq_route_oe,
    .irq_line_fourth, .irq_line_fourth_oe, .link_good, .media_select, .coax_power,
    .link_test_disable, .reduced_squelch, .twisted_pair_port, .serial_rom_reload);

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task do_reset(input logic [7:0] strap);
    @(posedge ref_clk);
    rst <= 1'b1;
    hw_config_strap <= strap;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    base = 16'h0300;
  endtask
  task reg_rd(input logic [3:0] ofs);
    i_host.io_cycle(1'b0, base + {12'h0, ofs}, 8'h00);
    #1;
    chk(rd_valid, 1'b1);
    d = rd_data;
  endtask
  // Reads just before writing; never writes back a read value, so the
  // link-test and fault bits are not disturbed by accident.
  task cfg_wr(input logic [3:0] ofs, input logic [7:0] v);
    reg_rd(ofs);
    i_host.io_cycle(1'b1, base + {12'h0, ofs}, v);
    #1;
    chk({rbc_write.rbc_lo_wr, rbc_write.rbc_hi_wr}, 16'h0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_hidden;
    logic [3:0] o;
    reg_rd(OFS_BUS_MODE);
    chk(d, BUS_MODE_RESET);
    cfg_wr(OFS_BUS_MODE, 8'hc8);
    reg_rd(OFS_BUS_MODE);
    chk(d, 8'hc8);
    chk(shared_memory_select, 1'b1);
    chk(early_port_fetch, 1'b0);
    for (int i = 0; i < 2; i++) begin
      o = i[0] ? OFS_MEDIA_OPT : OFS_BUS_MODE;
      reg_rd(o);
      reg_rd(i[0] ? OFS_BUS_MODE : OFS_MEDIA_OPT);
      i_host.io_cycle(1'b1, base + {12'h0, o}, 8'h5a);
      #1;
      chk(rbc_write, {~i[0], i[0], 8'h5a});
    end
    reg_rd(OFS_BUS_MODE);
    chk(d, 8'hc8);
    reg_rd(OFS_MEDIA_OPT);
    chk(d, 8'h04);
    cfg_wr(OFS_BUS_MODE, 8'h40);
    chk({shared_memory_select, early_port_fetch}, 2'b01);
  endtask
  task t_media;
    logic c;
    c = 1'b0;
    for (int m = 1; m < 5; m++) begin
      cfg_wr(OFS_MEDIA_OPT, {6'h0, m[1:0]});
      if (m[1:0] == MEDIA_THIN) c = 1'b1;
      else if (m[1:0] == MEDIA_THICK) c = 1'b0;
      reg_rd(OFS_MEDIA_OPT);
      chk(d[2], m[0] == m[1]);
      chk(media_select, m[1:0]);
      chk(reduced_squelch, m[1:0] == MEDIA_TP_LOW);
      chk(twisted_pair_port, m[0] == m[1]);
      chk(coax_power, c);
    end
  endtask
  task automatic t_link;
    logic [7:0] v [4] = '{8'h04, 8'h00, 8'h01, 8'h00};
    logic lk [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic ex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) link_good <= lk[i];
      cfg_wr(OFS_MEDIA_OPT, v[i]);
      reg_rd(OFS_MEDIA_OPT);
      chk(d[2], ex[i]);
      chk(link_test_disable, v[i][2]);
    end
  endtask
  task t_fault;
    @(posedge ref_clk) wait_wanted <= 1'b1;
    boot_wr_req <= 1'b1;
    @(posedge ref_clk) cycle_end <= 1'b1;
    @(posedge ref_clk) cycle_end <= 1'b0;
    wait_wanted <= 1'b0;
    reg_rd(OFS_MEDIA_OPT);
    chk(d[5], 1'b1);
    chk(boot_wr_cycle, 1'b0);
    cfg_wr(OFS_MEDIA_OPT, 8'h40);
    reg_rd(OFS_MEDIA_OPT);
    chk(d[5], 1'b1);
    chk(boot_wr_cycle, 1'b1);
    cfg_wr(OFS_MEDIA_OPT, 8'h20);
    reg_rd(OFS_MEDIA_OPT);
    chk(d[5], 1'b0);
    cfg_wr(OFS_MEDIA_OPT, 8'h08);
    i_host.hold(base, 1'b1, 1'b1);
    #1;
    chk({wide_io_ack, ready_arm}, 2'b00);
    i_host.hold(base, 1'b0, 1'b0);
    #1;
    chk({wide_io_ack, ready_arm}, 2'b11);
    cfg_wr(OFS_MEDIA_OPT, 8'h10);
    i_host.hold(base, 1'b1, 1'b1);
    #1;
    chk({wide_io_ack, ready_arm}, 2'b11);
    i_host.hold(base, 1'b0, 1'b0);
    #1;
    chk({wide_io_ack, ready_arm}, 2'b10);
    i_host.hold(16'h0000, 1'b1, 1'b0);
    cfg_wr(OFS_MEDIA_OPT, 8'h80);
    chk(serial_rom_reload, 1'b1);
  endtask
  task automatic t_base;
    logic [2:0] cd [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
    logic [15:0] ba [6] = '{16'h0240, 16'h0280, 16'h02c0, 16'h0320, 16'h0340, 16'h0300};
    for (int i = 0; i < 6; i++) begin
      cfg_wr(OFS_BUS_MODE, {5'h00, cd[i]});
      base = ba[i];
      reg_rd(OFS_BUS_MODE);
      chk(d[2:0], cd[i]);
      i_host.probe(ba[i] + 16'h001f);
      #1;
      chk(io_hit, 1'b1);
      i_host.probe(ba[i] + 16'h0020);
      #1;
      chk(io_hit, 1'b0);
    end
    cfg_wr(OFS_BUS_MODE, {5'h00, IO_BASE_SOFT});
    for (int i = 0; i < 13; i++) begin
      i_host.io_cycle(i != 3, (i == 3) ? 16'h0300 : SOFT_CFG_ADDR, (i > 8) ? 8'h00 : 8'h02);
      if (i == 4 || i == 8 || i == 12) begin
        i_host.probe(16'h0240);
        #1;
        chk(io_hit, i == 8);
      end
      if (i == 8) begin
        base = 16'h0240;
        cfg_wr(OFS_BUS_MODE, {5'h00, IO_BASE_SOFT});
      end
    end
  endtask
  task t_irq;
    do_reset(8'h00);
    @(posedge ref_clk) irq_req <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      cfg_wr(OFS_BUS_MODE, {2'b00, 1'b0, f[1:0], 3'h0});
      repeat (2) @(posedge ref_clk);
      #1;
      chk({irq_line_fourth_oe, irq_route_oe}, 4'h1 << f);
      chk({irq_line_fourth, irq_route_out}, 4'hf);
    end
    do_reset(8'h20);
    cfg_wr(OFS_BUS_MODE, 8'h28);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({irq_line_fourth_oe, irq_route_oe, irq_route_out}, 7'h7d);
    chk(irq_line_fourth, 1'b1);
    do_reset(8'h80);
    i_host.io_cycle(1'b0, 16'h030a, 8'h00);
    #1;
    chk(rd_valid, 1'b0);
    i_host.io_cycle(1'b1, 16'h030a, 8'h33);
    #1;
    chk(rbc_write, {1'b1, 1'b0, 8'h33});
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_sim;
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    rst = 1'b1;
    hw_config_strap = 8'h00;
    page0_sel = 1'b1;
    wait_wanted = 1'b0;
    cycle_end = 1'b0;
    port_read_active = 1'b1;
    boot_wr_req = 1'b0;
    irq_req = 1'b0;
    link_good = 1'b1;
    do_reset(8'h00);
    t_hidden;
    t_media;
    t_link;
    t_fault;
    t_base;
    t_irq;
    end_sim;
  end
endmodule
